// file: rtl/ssir_consts.svh
// constants for the ssi channel readout block
`ifndef SSIR_CONSTS_SVH
`define SSIR_CONSTS_SVH
`define SSIR_CLK_MHZ 100
`define SSIR_HALF_125K 16'd400
`define SSIR_HALF_250K 16'd200
`define SSIR_HALF_500K 16'd100
`define SSIR_HALF_1M 16'd50
`define SSIR_IDLE_1CH_US 120
`define SSIR_IDLE_2CH_US 360
`define SSIR_IDLE_3CH_US 600
`define SSIR_IDLE_4CH_US 850
`define SSIR_IDLE_CYC(us) (17'((us) * `SSIR_CLK_MHZ))
`define SSIR_RATE_125K 2'h0
`define SSIR_RATE_250K 2'h1
`define SSIR_RATE_500K 2'h2
`define SSIR_RATE_1M 2'h3
`define SSIR_LATCH_RISE 1
`define SSIR_LATCH_FALL 0
`define SSIR_BITS_MAX 6'd32
`define SSIR_BIT_ONE 6'd1
`define SSIR_US_PER_S 32'd1000000
`endif

// file: rtl/ssir_pkg.sv
// types shared by the ssi channel readout block
package ssir_pkg;
  typedef enum logic [1:0] {
    SSIR_IDLE = 2'b00,
    SSIR_LOW = 2'b01,
    SSIR_HIGH = 2'b10,
    SSIR_GAP = 2'b11
  } ssir_state_t;

  typedef struct packed {
    logic [1:0] rate;
    logic [5:0] clk_bits;
    logic [5:0] msb_pos;
    logic [5:0] data_bits;
    logic gray;
    logic neg_logic;
    logic [1:0] latch_mode;
    logic [1:0] num_ch;
    logic [31:0] sp_on;
    logic [31:0] sp_off;
  } ssir_cfg_t;

  typedef struct packed {
    logic [31:0] value;
    logic [31:0] raw;
    logic [31:0] latched;
    logic latch_level;
    logic limit;
    logic [31:0] interp;
    logic interp_limit;
    logic valid;
  } ssir_stat_t;
endpackage

// file: rtl/ssir_decode.sv
// field extraction, inversion and gray decode of one frame
`timescale 1ns/1ps
`include "ssir_consts.svh"
module ssir_decode
  import ssir_pkg::*;
(
  input wire logic [31:0] shift_i,
  input wire logic [5:0] clk_bits_i,
  input wire ssir_cfg_t cfg_i,
  output logic [31:0] value_o
);
  logic [31:0] stream;
  logic [31:0] field;
  logic [31:0] mask;
  logic [5:0] lsb_pos;
  always_comb begin
    stream = cfg_i.neg_logic ? ~shift_i : shift_i;
    lsb_pos = 6'(cfg_i.msb_pos + cfg_i.data_bits - `SSIR_BIT_ONE);
    field = stream >> (clk_bits_i - lsb_pos);
    mask = (cfg_i.data_bits >= `SSIR_BITS_MAX) ? 32'hffffffff :
      ((32'h1 << cfg_i.data_bits) - 32'h1);
    field = field & mask;
    if (cfg_i.gray) begin
      for (int i = 30; i >= 0; i--) begin
        field[i] = field[i] ^ field[i+1];
      end
    end
    value_o = field;
  end
endmodule

// file: rtl/ssir_channel.sv
// one ssi channel: clocking, framing, latch, limits, interpolation
`timescale 1ns/1ps
`include "ssir_consts.svh"
module ssir_channel
  import ssir_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  input wire ssir_cfg_t cfg_i,
  input wire logic sdata_i,
  input wire logic latch_in_i,
  input wire logic [31:0] time_lo_i,
  input wire logic [31:0] time_hi_i,
  input wire logic xmit_i,
  input wire logic signed [31:0] velocity_i,
  input wire logic [31:0] now_us_i,
  output logic sclk_o,
  output ssir_stat_t stat_o
);
  typedef struct packed {
    ssir_state_t st;
    logic sclk;
    logic [15:0] div;
    logic [16:0] gap;
    logic [5:0] cnt;
    logic [5:0] nbits;
    logic [31:0] shift;
    logic [1:0] sd_sync;
    logic [2:0] lt_sync;
    logic [2:0] xm_sync;
    logic [31:0] tgt_lo;
    logic [31:0] frame_us;
    ssir_stat_t stat;
  } ssir_reg_t;

  ssir_reg_t r_ff;
  ssir_reg_t nxt_r;
  logic [31:0] dec_value;
  logic [31:0] ahead_us;
  logic signed [63:0] delta;
  logic [31:0] interp;
  logic [15:0] half;
  logic [16:0] idle;
  logic lt_rise;
  logic lt_fall;
  logic xm_tgl;

  function automatic logic in_window(input logic [31:0] v, input logic [31:0] on,
                                     input logic [31:0] off);
    if (on < off) begin
      in_window = (v >= on) && (v <= off);
    end else if (on > off) begin
      in_window = (v < off) || (v > on);
    end else begin
      in_window = 1'b0;
    end
  endfunction

  ssir_decode u_dec (
    .shift_i(r_ff.shift),
    .clk_bits_i(r_ff.nbits),
    .cfg_i(cfg_i),
    .value_o(dec_value)
  );

  always_comb begin
    case (cfg_i.rate)
      `SSIR_RATE_125K: half = `SSIR_HALF_125K;
      `SSIR_RATE_250K: half = `SSIR_HALF_250K;
      `SSIR_RATE_500K: half = `SSIR_HALF_500K;
      default: half = `SSIR_HALF_1M;
    endcase
    case (cfg_i.num_ch)
      2'h0: idle = `SSIR_IDLE_CYC(`SSIR_IDLE_1CH_US);
      2'h1: idle = `SSIR_IDLE_CYC(`SSIR_IDLE_2CH_US);
      2'h2: idle = `SSIR_IDLE_CYC(`SSIR_IDLE_3CH_US);
      default: idle = `SSIR_IDLE_CYC(`SSIR_IDLE_4CH_US);
    endcase
  end

  assign lt_rise = r_ff.lt_sync[1] & ~r_ff.lt_sync[2];
  assign lt_fall = ~r_ff.lt_sync[1] & r_ff.lt_sync[2];
  assign xm_tgl = r_ff.xm_sync[1] ^ r_ff.xm_sync[2];

  // linear prediction, velocity in counts per second
  always_comb begin
    ahead_us = r_ff.tgt_lo - r_ff.frame_us;
    delta = (64'(velocity_i) * $signed({32'h0, ahead_us})) / $signed({32'h0, `SSIR_US_PER_S});
    interp = r_ff.stat.value + delta[31:0];
  end

  always_comb begin
    nxt_r = r_ff;
    nxt_r.sd_sync = {r_ff.sd_sync[0], sdata_i};
    nxt_r.lt_sync = {r_ff.lt_sync[1:0], latch_in_i};
    nxt_r.xm_sync = {r_ff.xm_sync[1:0], xmit_i};
    nxt_r.stat.latch_level = r_ff.lt_sync[1];
    if ((lt_rise && cfg_i.latch_mode[`SSIR_LATCH_RISE]) ||
        (lt_fall && cfg_i.latch_mode[`SSIR_LATCH_FALL])) begin
      nxt_r.stat.latched = r_ff.stat.value;
    end
    if (xm_tgl) begin
      // low word in microseconds; high word unused for short look-ahead
      nxt_r.tgt_lo = time_lo_i;
    end
    case (r_ff.st)
      SSIR_IDLE: begin
        nxt_r.sclk = 1'b1;
        nxt_r.div = half;
        nxt_r.cnt = 6'h0;
        nxt_r.nbits = cfg_i.clk_bits;
        nxt_r.shift = 32'h0;
        nxt_r.sclk = 1'b0;
        nxt_r.st = SSIR_LOW;
      end
      SSIR_LOW: begin
        if (r_ff.div <= 16'h1) begin
          nxt_r.sclk = 1'b1;
          nxt_r.div = half;
          nxt_r.st = SSIR_HIGH;
        end else begin
          nxt_r.div = r_ff.div - 16'h1;
        end
      end
      SSIR_HIGH: begin
        if (r_ff.div <= 16'h1) begin
          // sample late in high half so sensor output has settled
          nxt_r.shift = {r_ff.shift[30:0], r_ff.sd_sync[1]};
          nxt_r.cnt = r_ff.cnt + 6'h1;
          nxt_r.div = half;
          if (r_ff.cnt + 6'h1 >= r_ff.nbits) begin
            nxt_r.gap = idle;
            nxt_r.st = SSIR_GAP;
          end else begin
            nxt_r.sclk = 1'b0;
            nxt_r.st = SSIR_LOW;
          end
        end else begin
          nxt_r.div = r_ff.div - 16'h1;
        end
      end
      default: begin
        if (r_ff.gap == 17'h0) begin
          nxt_r.st = SSIR_IDLE;
        end else begin
          nxt_r.gap = r_ff.gap - 17'h1;
        end
      end
    endcase
    // frame completion: publish decoded value
    if (r_ff.st == SSIR_GAP && r_ff.gap == idle) begin
      nxt_r.stat.raw = r_ff.shift;
      nxt_r.stat.value = dec_value;
      nxt_r.frame_us = now_us_i;
      nxt_r.stat.valid = 1'b1;
      nxt_r.stat.limit = in_window(dec_value, cfg_i.sp_on, cfg_i.sp_off);
    end
    nxt_r.stat.interp = interp;
    nxt_r.stat.interp_limit = in_window(interp, cfg_i.sp_on, cfg_i.sp_off);
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r_ff <= '0;
      r_ff.sclk <= 1'b1;
    end else if (enable_i) begin
      r_ff <= nxt_r;
    end
  end

  assign sclk_o = r_ff.sclk;
  assign stat_o = r_ff.stat;
endmodule

// file: dv/ssir_sensor.sv
// behavioural ssi position sensor
`timescale 1ns/1ps
module ssir_sensor (
  input wire logic sclk_i,
  input wire logic [31:0] word_i,
  output logic sdata_o = 1'h1
);
  logic [31:0] sh;
  logic busy = 1'h0;
  realtime t_up = 0;
  always @(negedge sclk_i) if (!busy) begin
    busy = 1'h1;
    sh = word_i;
  end
  always @(posedge sclk_i) if (busy) begin
    t_up = $realtime;
    {sdata_o, sh} = {sh, 1'h1};
  end
  // pulled high once the clock has rested
  always #1000 if (busy && sclk_i && $realtime - t_up > 15000) begin
    busy = 1'h0;
    sdata_o = 1'h1;
  end
endmodule

// file: dv/ssir_channel_sva.sv
// assertions for the ssi channel readout
`timescale 1ns/1ps
`include "ssir_consts.svh"
module ssir_channel_sva
  import ssir_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire ssir_cfg_t cfg_i,
  input wire logic latch_in_i,
  input wire logic sclk_o,
  input wire ssir_stat_t stat_o
);
  // high this long only in the idle gap, never within a bit
  localparam int GAP_MARK = 1000;
  logic [16:0] lo_ff, hi_ff, half;
  logic [5:0] rc_ff;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  assign half = 17'(`SSIR_HALF_1M << (2'h3 - cfg_i.rate));
  function automatic logic lim(logic [31:0] v, logic [31:0] on, logic [31:0] off);
    if (on < off) return v >= on && v <= off;
    return on > off && (v < off || v > on);
  endfunction
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lo_ff <= 17'h0;
      hi_ff <= 17'h0;
      rc_ff <= 6'h0;
    end else begin
      lo_ff <= sclk_o ? 17'h0 : lo_ff + 17'h1;
      hi_ff <= sclk_o ? hi_ff + 17'h1 : 17'h0;
      if (!sclk_o && hi_ff > 17'(GAP_MARK)) rc_ff <= 6'h0;
      else if (sclk_o && lo_ff != 17'h0) rc_ff <= rc_ff + 6'h1;
    end
  end
  chk_reset_clear: assert property (disable iff (1'h0)
    !resetn_i |-> stat_o == '0 && sclk_o) else $error("not cleared in reset");
  chk_low_half: assert property (
    $rose(sclk_o) |-> lo_ff == half) else $error("wrong clock low time");
  chk_bit_count: assert property (
    hi_ff == 17'(GAP_MARK) |-> rc_ff == cfg_i.clk_bits) else $error("wrong pulse count");
  chk_limit_win: assert property (
    $changed(stat_o.value) |-> stat_o.limit == lim(stat_o.value, cfg_i.sp_on, cfg_i.sp_off))
    else $error("wrong limit bit");
  chk_interp_lim: assert property (
    $changed(stat_o.interp) |-> stat_o.interp_limit == lim(stat_o.interp, cfg_i.sp_on,
    cfg_i.sp_off)) else $error("wrong interpolated limit bit");
  chk_level_follow: assert property (
    $stable(latch_in_i) [*5] |-> stat_o.latch_level == latch_in_i) else $error("bad level");
  chk_latch_edge: assert property (
    $changed(stat_o.latched) |-> ##[0:2] (cfg_i.latch_mode[1] && stat_o.latch_level ||
    cfg_i.latch_mode[0] && !stat_o.latch_level)) else $error("capture on unselected edge");
  chk_latch_val: assert property (
    $rose(stat_o.latch_level) && cfg_i.latch_mode[1] |-> ##[0:3] stat_o.latched == stat_o.value)
    else $error("rising edge not captured");
  cover property ($rose(stat_o.latch_level));
  cover property (stat_o.limit && $changed(stat_o.value));
  cover property ($changed(stat_o.interp));
endmodule
bind ssir_channel ssir_channel_sva u_sva (.clock_i, .resetn_i, .cfg_i, .latch_in_i, .sclk_o,
  .stat_o);

// file: dv/ssir_channel_tb.sv
// self-checking bench for the ssi channel readout
`timescale 1ns/1ps
module ssir_channel_tb;
  import ssir_pkg::*;
  logic clock_i = 1'h0, resetn_i = 1'h1, latch_in_i = 1'h0, xmit_i = 1'h0, sdata_i, sclk_o;
  logic [31:0] word = 32'h5a3c96e1, tlo = 32'h0, e;
  ssir_cfg_t cfg_i = '{2'h3, 6'h18, 6'h01, 6'h18, 1'h0, 1'h0, 2'h0, 2'h0, 32'h0, 32'h0};
  ssir_stat_t stat_o;
  int err_count = 0, tests_run = 0;
  always #5 clock_i = ~clock_i;
  ssir_channel u_dut (.clock_i, .resetn_i, .enable_i(1'h1), .cfg_i, .sdata_i, .latch_in_i,
    .time_lo_i(tlo), .time_hi_i(32'h0), .xmit_i, .velocity_i(32'sh000f4240),
    .now_us_i(32'h1000), .sclk_o, .stat_o);
  ssir_sensor u_snr (.sclk_i(sclk_o), .word_i(word), .sdata_o(sdata_i));
  task stop_test;
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(string n, logic [31:0] x, logic [31:0] s);
    tests_run++;
    if (s !== x) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, x, s);
    end
  endtask
  // returns in the idle gap, results of the frame published
  task frame;
    @(negedge sclk_o);
    repeat (5000) @(posedge clock_i);
    #1;
  endtask
  function automatic logic [31:0] fld(ssir_cfg_t c, logic [31:0] w);
    logic [31:0] g, b;
    g = 32'(((c.neg_logic ? ~w : w) >> (6'h21 - c.msb_pos - c.data_bits)) &
      ((64'h1 << c.data_bits) - 64'h1));
    b = g;
    for (int i = 1; i < 32; i++) b ^= c.gray ? g >> i : 32'h0;
    return b;
  endfunction
  task s_reset;
    // a real falling edge, so the asynchronous reset branch surely runs
    #1 resetn_i = 1'h0;
    repeat (5) @(posedge clock_i);
    #1 resetn_i = 1'h1;
    chk("latched", 32'h0, stat_o.latched);
    e = fld(cfg_i, word);
    frame;
    chk("value", e, stat_o.value);
    chk("raw", word >> 8, stat_o.raw);
    chk("valid", 32'h1, 32'(stat_o.valid));
  endtask
  task s_latch_fall;
    cfg_i.latch_mode = 2'h1;
    latch_in_i = 1'h1;
    repeat (20000) @(posedge clock_i);
    #1 chk("level", 32'h1, 32'(stat_o.latch_level));
    chk("latched", 32'h0, stat_o.latched);
    latch_in_i = 1'h0;
    repeat (10) @(posedge clock_i);
    #1 chk("latched", e, stat_o.latched);
  endtask
  task s_decode;
    // each count just covers its field
    logic [5:0] cb[4] = '{6'h01, 6'h04, 6'h10, 6'h20};
    logic [5:0] mp[4] = '{6'h01, 6'h02, 6'h03, 6'h01};
    logic [5:0] nb[4] = '{6'h01, 6'h03, 6'h0e, 6'h20};
    logic [1:0] dn[4] = '{2'h0, 2'h1, 2'h2, 2'h1};
    logic [1:0] df[4] = '{2'h1, 2'h2, 2'h1, 2'h0};
    for (int i = 0; i < 4; i++) begin
      cfg_i.rate = 2'(i);
      cfg_i.clk_bits = cb[i];
      cfg_i.msb_pos = mp[i];
      cfg_i.data_bits = nb[i];
      cfg_i.neg_logic = i[1];
      cfg_i.gray = i[0];
      e = fld(cfg_i, word);
      cfg_i.sp_on = e + 32'(dn[i]);
      cfg_i.sp_off = e + 32'(df[i]);
      frame;
      chk("value", e, stat_o.value);
      chk("limit", 32'(!i[0]), 32'(stat_o.limit));
    end
  endtask
  task s_interp;
    cfg_i.latch_mode = 2'h2;
    latch_in_i = 1'h1;
    tlo = 32'h1064;
    xmit_i = 1'h1;
    repeat (10) @(posedge clock_i);
    #1 chk("latched", e, stat_o.latched);
    // look-ahead of 250 us in the low word
    tlo = 32'h10fa;
    xmit_i = 1'h0;
    frame;
    chk("interp", e + 32'hfa, stat_o.interp);
    chk("ilimit", 32'h1, 32'(stat_o.interp_limit));
    latch_in_i = 1'h0;
  endtask
  initial begin
    s_reset;
    s_latch_fall;
    s_decode;
    s_interp;
    stop_test;
  end
  // about two thirds again the expected run
  initial begin
    #1500000;
    err_count++;
    stop_test;
  end
endmodule
